/* hw/tmsr_top.sv */
// serial slave, register file and conversion control of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tmsr_top #(
  parameter int unsigned CONV_CYC    = tmsr_pkg::CONV_CYC,
  parameter int unsigned LOCK_CYC    = tmsr_pkg::LOCK_CYC,
  parameter int unsigned TIMEOUT_CYC = tmsr_pkg::TIMEOUT_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire logic                  addr_tied_high,
  input  wire logic                  addr_tied_low,
  input  wire tmsr_pkg::tmsr_meas_s  meas,
  output logic                       conv_start,
  output logic                       conv_active
);
  import tmsr_pkg::*;

  localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYC - 1);

  tmsr_pins_s       pins;
  tmsr_pins_s       pins_s;
  tmsr_temp_s       temps;
  tmsr_state_e      state;
  tmsr_state_e      next_state;
  logic             scl_q;
  logic             sda_q;
  logic [3:0]       bit_cnt;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       sh;
  logic [7:0]       next_sh;
  logic             rw;
  logic             next_rw;
  logic [7:0]       ptr;
  logic [7:0]       next_ptr;
  logic [7:0]       cfg;
  logic [7:0]       next_cfg;
  logic             next_sda_oe;
  logic             rd_stb;
  logic             next_rd_stb;
  logic             wr_stb;
  logic             next_wr_stb;
  logic             cmd_stb;
  logic             next_cmd_stb;
  logic [CNT_W-1:0] to_cnt;
  logic [CNT_W-1:0] next_to_cnt;
  logic [6:0]       my_addr;
  logic             start_c;
  logic             stop_c;
  logic             scl_rise;
  logic             scl_fall;
  logic             timeout;

  // every location reads as one byte; unused pointers read as zero
  function automatic logic [7:0] reg_read(input logic [7:0] a, input tmsr_temp_s t, input logic [7:0] c);
    case (a)
      REG_CH1_TEMP:   reg_read = t.ch1_temp; // R6
      REG_CH2_TEMP:   reg_read = t.ch2_temp; // R6
      REG_GLOBAL_CFG: reg_read = c;
      REG_CH1_FRAC:   reg_read = t.ch1_frac;
      REG_CH2_FRAC:   reg_read = t.ch2_frac;
      default:        reg_read = READ_UNMAPPED;
    endcase
  endfunction

  assign pins = '{scl: scl_in, sda: sda_in, addr_hi: addr_tied_high, addr_lo: addr_tied_low};

  tmsr_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (pins),
    .q       (pins_s)
  );

  tmsr_conv #(
    .CONV_CYC (CONV_CYC),
    .LOCK_CYC (LOCK_CYC)
  ) u_conv (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .shutdown   (cfg[CFG_SHDN_BIT]),
    .meas       (meas),
    .rd_stb     (rd_stb),
    .rd_addr    (ptr),
    .conv_start (conv_start),
    .temps      (temps)
  );

  // floating strap: neither the high nor the low sense fires
  always_comb begin
    if (pins_s.addr_hi) begin
      my_addr = SLAVE_ADDR_VCC; // R3
    end else if (pins_s.addr_lo) begin
      my_addr = SLAVE_ADDR_GND; // R3
    end else begin
      my_addr = SLAVE_ADDR_FLOAT; // R3
    end
  end

  assign start_c  = scl_q && pins_s.scl && sda_q && !pins_s.sda;
  assign stop_c   = scl_q && pins_s.scl && !sda_q && pins_s.sda;
  assign scl_rise = !scl_q && pins_s.scl;
  assign scl_fall = scl_q && !pins_s.scl;
  assign timeout  = !pins_s.scl && (to_cnt == TO_LAST); // R15
  assign sda_out  = 1'b0;
  assign conv_active = !cfg[CFG_SHDN_BIT];

  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_sh      = sh;
    next_rw      = rw;
    next_ptr     = ptr;
    next_cfg     = cfg;
    next_sda_oe  = sda_oe;
    next_rd_stb  = 1'b0;
    next_wr_stb  = 1'b0;
    next_cmd_stb = 1'b0;
    next_to_cnt  = pins_s.scl ? '0 : (timeout ? to_cnt : to_cnt + 1'b1);
    // a stuck-low clock drops any transfer and frees the data line
    if (timeout) begin
      next_state  = ST_IDLE; // R15
      next_sda_oe = 1'b0;
    end else if (start_c) begin
      next_state   = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_c) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_WAIT: begin
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            next_sh      = {sh[6:0], pins_s.sda};
            next_bit_cnt = bit_cnt + 1'b1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b1;
            if (state == ST_ADDR) begin
              if (sh[7:1] == my_addr) begin
                next_state = ST_ADDR_ACK; // R3
                next_rw    = sh[0];
              end else begin
                next_state  = ST_WAIT;
                next_sda_oe = 1'b0;
              end
            end else if (state == ST_CMD) begin
              next_state   = ST_CMD_ACK;
              next_ptr     = sh; // R2
              next_cmd_stb = 1'b1;
            end else begin
              // read-only and unused locations take the ack but keep their value
              next_state  = ST_WDATA_ACK; // R17
              next_wr_stb = 1'b1;
              if (ptr == REG_GLOBAL_CFG) begin
                next_cfg = sh; // R5
              end
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_state  = ST_WDATA; // R1
            next_sda_oe = 1'b0;
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (state == ST_RDATA_ACK && scl_rise && pins_s.sda) begin
            next_state = ST_WAIT;
          end else if (scl_fall && (state == ST_RDATA_ACK || !rw)) begin
            next_state   = ST_CMD;
            next_sda_oe  = 1'b0;
            if (rw) begin
              next_state  = ST_RDATA; // R2
              next_sh     = reg_read(ptr, temps, cfg);
              next_sda_oe = !next_sh[7];
              next_rd_stb = 1'b1;
            end
          end else if (scl_fall) begin
            next_state  = ST_RDATA; // R2
            next_sh     = reg_read(ptr, temps, cfg);
            next_sda_oe = !next_sh[7];
            next_rd_stb = 1'b1;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 1'b1;
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              next_state   = ST_RDATA_ACK;
              next_sda_oe  = 1'b0;
              next_bit_cnt = 4'h0;
            end else begin
              next_sh     = {sh[6:0], 1'b0}; // R8
              next_sda_oe = !sh[6];
            end
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_cnt <= 4'h0;
      sh      <= 8'h00;
      rw      <= 1'b0;
      ptr     <= REG_CH1_TEMP;
      cfg     <= CFG_RST;
      sda_oe  <= 1'b0;
      rd_stb  <= 1'b0;
      wr_stb  <= 1'b0;
      cmd_stb <= 1'b0;
      to_cnt  <= '0;
    end else if (ce) begin
      state   <= next_state;
      scl_q   <= pins_s.scl;
      sda_q   <= pins_s.sda;
      bit_cnt <= next_bit_cnt;
      sh      <= next_sh;
      rw      <= next_rw;
      ptr     <= next_ptr;
      cfg     <= next_cfg;
      sda_oe  <= next_sda_oe;
      rd_stb  <= next_rd_stb;
      wr_stb  <= next_wr_stb;
      cmd_stb <= next_cmd_stb;
      to_cnt  <= next_to_cnt;
    end
  end

  a_addr_decode: assert property (@(posedge clk) disable iff (sys_rst) // R3
      pins_s.addr_hi |-> my_addr == 7'h2F)
    else $error("strap high did not select address 0101111");
  a_msb_first: assert property (@(posedge clk) disable iff (sys_rst) // R8
      state == ST_RDATA |-> sda_oe == !sh[7])
    else $error("data line does not carry the shift register msb");
  a_timeout_idle: assert property (@(posedge clk) disable iff (sys_rst) // R15
      ce && timeout |=> state == ST_IDLE && !sda_oe)
    else $error("clock-low timeout did not free the interface");
  a_ptr_load: assert property (@(posedge clk) disable iff (sys_rst) // R2
      cmd_stb |-> ptr == $past(sh))
    else $error("pointer not loaded from command byte");
  a_ro_keep: assert property (@(posedge clk) disable iff (sys_rst) // R17
      wr_stb && ptr != REG_GLOBAL_CFG |-> $stable(cfg))
    else $error("write to another location changed the configuration");
  a_cfg_write: assert property (@(posedge clk) disable iff (sys_rst) // R5
      wr_stb && ptr == REG_GLOBAL_CFG |-> cfg == sh)
    else $error("configuration write lost its data byte");
endmodule
`default_nettype wire

/* hw/tmsr_pkg.sv */
// constants, types and layouts shared by the temperature monitor serial front end
// Behaviour
// R1: serial access uses write byte, read byte, send byte and receive byte only.
// R2: receive byte returns the register last selected by a command byte.
// R3: slave address from select pin: high 0101111, floating 0101110, ground 0101100.
// R4: multi-master hosts should avoid short forms; pointer may be changed.
// R5: every register is one byte, selected by command byte, one byte per access.
// R6: main temperatures sit at 00h and 01h, readable at any time.
// R7: main temperature byte is unsigned, LSB 1 degree, MSB 128 degrees.
// R8: data bytes are shifted out most significant bit first.
// R9: three fraction bits (eighth degree) live at 05h and 06h.
// R10: temperatures below zero are stored and reported as 00h.
// R11: fraction read freezes matching main register for at least 0.25 s.
// R12: freeze ends early when the main register is read.
// R13: conversions run at 4 Hz from power-up without a command.
// R14: config bit 7 at 04h stops the measurement cycle.
// R15: serial logic returns to idle when clock low past 58 to 90 ms.
// R16: while shut down, results stay readable and serial access keeps working.
// R17: writes to read-only registers are acknowledged, ignored, pointer still updated.
package tmsr_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned NS_PER_MS      = 1_000_000;
  localparam int unsigned CONV_PERIOD_MS = 250;
  localparam int unsigned LOCK_MIN_MS    = 250;
  localparam int unsigned TIMEOUT_MIN_MS = 58;
  localparam int unsigned TIMEOUT_MAX_MS = 90;
  localparam int unsigned CONV_CYC       = CONV_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYC       = (LOCK_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_CYC    = (TIMEOUT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 25;

  localparam logic [7:0] REG_CH1_TEMP   = 8'h00;
  localparam logic [7:0] REG_CH2_TEMP   = 8'h01;
  localparam logic [7:0] REG_GLOBAL_CFG = 8'h04;
  localparam logic [7:0] REG_CH1_FRAC   = 8'h05;
  localparam logic [7:0] REG_CH2_FRAC   = 8'h06;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [7:0] TEMP_RST       = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
  localparam int unsigned CFG_SHDN_BIT  = 7;
  localparam logic [4:0] FRAC_PAD       = 5'h00;

  localparam logic [6:0] SLAVE_ADDR_VCC   = 7'h2F;
  localparam logic [6:0] SLAVE_ADDR_FLOAT = 7'h2E;
  localparam logic [6:0] SLAVE_ADDR_GND   = 7'h2C;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hC,
    ST_WAIT      = 4'hD
  } tmsr_state_e;

  // pins from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic addr_hi;
    logic addr_lo;
  } tmsr_pins_s;

  // conversion result, two's complement in eighths of a degree
  typedef struct packed {
    logic [11:0] ch1;
    logic [11:0] ch2;
    logic        valid;
  } tmsr_meas_s;

  typedef struct packed {
    logic [7:0] ch1_temp;
    logic [7:0] ch2_temp;
    logic [7:0] ch1_frac;
    logic [7:0] ch2_frac;
  } tmsr_temp_s;

endpackage

/* hw/tmsr_sync.sv */
// two flip-flop synchroniser for the external pins
`timescale 1ns/1ps
`default_nettype none
module tmsr_sync (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire tmsr_pkg::tmsr_pins_s d,
  output var  tmsr_pkg::tmsr_pins_s q
);
  import tmsr_pkg::*;

  tmsr_pins_s meta;
  tmsr_pins_s next_meta;
  tmsr_pins_s next_q;

  // idle bus level is high; address straps reset to floating
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= '{scl: 1'b1, sda: 1'b1, addr_hi: 1'b0, addr_lo: 1'b0};
      q    <= '{scl: 1'b1, sda: 1'b1, addr_hi: 1'b0, addr_lo: 1'b0};
    end else if (ce) begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule
`default_nettype wire

/* hw/tmsr_conv.sv */
// conversion schedule, result clipping and fraction-read lock
`timescale 1ns/1ps
`default_nettype none
module tmsr_conv #(
  parameter int unsigned CONV_CYC = tmsr_pkg::CONV_CYC,
  parameter int unsigned LOCK_CYC = tmsr_pkg::LOCK_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic                  shutdown,
  input  wire tmsr_pkg::tmsr_meas_s  meas,
  input  wire logic                  rd_stb,
  input  wire logic [7:0]            rd_addr,
  output logic                       conv_start,
  output tmsr_pkg::tmsr_temp_s       temps
);
  import tmsr_pkg::*;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);

  logic [CNT_W-1:0]       conv_cnt;
  logic [CNT_W-1:0]       next_conv_cnt;
  logic                   next_conv_start;
  logic [1:0][7:0]        main_t;
  logic [1:0][7:0]        frac_t;
  logic [1:0]             lock;
  logic [1:0][CNT_W-1:0]  lock_cnt;
  logic [1:0][7:0]        next_main_t;
  logic [1:0][7:0]        next_frac_t;
  logic [1:0]             next_lock;
  logic [1:0][CNT_W-1:0]  next_lock_cnt;
  logic [1:0][11:0]       raw;

  // negative readings clip to zero, otherwise integer and fraction parts
  function automatic logic [10:0] clip(input logic [11:0] r);
    clip = r[11] ? 11'h000 : r[10:0]; // R10
  endfunction

  assign raw = {meas.ch2, meas.ch1};

  always_comb begin
    logic [10:0] c;
    c               = 11'h000;
    next_conv_cnt   = conv_cnt;
    next_conv_start = 1'b0;
    next_main_t     = main_t;
    next_frac_t     = frac_t;
    next_lock       = lock;
    next_lock_cnt   = lock_cnt;
    // counter parks at zero while shut down so a wake-up converts at once
    if (shutdown) begin
      next_conv_cnt = '0; // R14
    end else begin
      next_conv_start = (conv_cnt == '0); // R13
      next_conv_cnt   = (conv_cnt == CONV_LAST) ? '0 : conv_cnt + 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (lock[i]) begin
        next_lock_cnt[i] = lock_cnt[i] - 1'b1;
        if (lock_cnt[i] == '0) begin
          next_lock[i] = 1'b0; // R11
        end
      end
      if (rd_stb && rd_addr == (i == 0 ? REG_CH1_TEMP : REG_CH2_TEMP)) begin
        next_lock[i] = 1'b0; // R12
      end
      if (rd_stb && rd_addr == (i == 0 ? REG_CH1_FRAC : REG_CH2_FRAC)) begin
        next_lock[i]     = 1'b1; // R11
        next_lock_cnt[i] = LOCK_LAST;
      end
      // results of a stopped cycle are dropped; old values stay readable
      if (meas.valid && !shutdown) begin // R16
        c              = clip(raw[i]);
        next_frac_t[i] = {c[2:0], FRAC_PAD}; // R9
        if (!lock[i]) begin
          next_main_t[i] = c[10:3]; // R7
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_cnt   <= '0;
      conv_start <= 1'b0;
      main_t     <= {2{TEMP_RST}};
      frac_t     <= {2{TEMP_RST}};
      lock       <= 2'h0;
      lock_cnt   <= '0;
    end else if (ce) begin
      conv_cnt   <= next_conv_cnt;
      conv_start <= next_conv_start;
      main_t     <= next_main_t;
      frac_t     <= next_frac_t;
      lock       <= next_lock;
      lock_cnt   <= next_lock_cnt;
    end
  end

  assign temps = '{ch1_temp: main_t[0], ch2_temp: main_t[1], ch1_frac: frac_t[0], ch2_frac: frac_t[1]};

  a_conv_stop: assert property (@(posedge clk) disable iff (sys_rst) ce && shutdown |=> !conv_start) // R14
    else $error("conversion started while shut down");
  a_neg_clip: assert property (@(posedge clk) disable iff (sys_rst)
      ce && meas.valid && !shutdown && meas.ch1[11] && !lock[0] |=> main_t[0] == 8'h00 && frac_t[0] == 8'h00) // R10
    else $error("negative reading not clipped to zero");
  a_frac_format: assert property (@(posedge clk) disable iff (sys_rst)
      ce && meas.valid && !shutdown && !meas.ch2[11] |=> frac_t[1] == {$past(meas.ch2[2:0]), FRAC_PAD}) // R9
    else $error("fraction register holds wrong bits");
  a_lock_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ce && lock[1] && meas.valid |=> $stable(main_t[1])) // R11
    else $error("main register updated while locked");
  a_lock_release: assert property (@(posedge clk) disable iff (sys_rst)
      ce && rd_stb && rd_addr == REG_CH1_TEMP |=> !lock[0]) // R12
    else $error("main read did not end the lock");
endmodule
`default_nettype wire

/* dv/tmsr_host.sv */
// behavioural serial bus host that drives the clock line and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module tmsr_host (
  output var  logic scl,
  output var  logic sda_oe,
  input  wire logic sda
);
  // quarter of the 125 ns bit time; data bits move in mid low phase, start and stop edges with the clock high
  localparam realtime Q = 31.25;

  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // transfers are built as write, read, send and receive byte, plus address-only probes
  // single master here, so the short forms cannot be upset by a second host

  // also serves as repeated start: releases data while the clock is low
  task automatic start();
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(2 * Q);
  endtask

  task automatic bit_io(input logic o, output logic i);
    sda_oe = ~o;
    #Q scl = 1'b1;
    #Q i = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int k = 7; k >= 0; k--) begin
      bit_io(b[k], d);
    end
    bit_io(1'b1, d);
    ack = ~d;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic d;
    for (int k = 7; k >= 0; k--) begin
      bit_io(1'b1, b[k]);
    end
    bit_io(~ack, d);
  endtask
endmodule
`default_nettype wire

/* dv/tmsr_top_tb.sv */
// self-checking bench for the temperature monitor serial front end
`timescale 1ns/1ps
`default_nettype none
module tmsr_top_tb;
  import tmsr_pkg::*;
  // short counts so that lock outlives a conversion plus one read
  localparam int unsigned T_CONV = 1000;
  localparam int unsigned T_LOCK = 4000;
  localparam int unsigned T_TOUT = 300;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  logic        scl;
  logic        host_oe;
  wire  logic  sda;
  logic        sda_out;
  logic        sda_oe;
  logic        addr_hi;
  logic        addr_lo;
  tmsr_meas_s  meas;
  logic        conv_start;
  logic        conv_active;
  logic [11:0] ch1_val;
  logic [11:0] ch2_val;
  logic [6:0]  dev_addr;
  int          mismatches = 0;
  int          compares = 0;
  int          n_starts = 0;
  int          cyc = 0;
  int          last_t = 0;
  int          last_gap = 0;
  logic [11:0] tv [4] = '{12'd204, 12'd1928, 12'd1015, 12'hFE8};
  logic [7:0]  tm [4] = '{8'h19, 8'hF1, 8'h7E, 8'h00};
  logic [7:0]  tf [4] = '{8'h80, 8'h00, 8'hE0, 8'h00};
  logic [1:0]  straps [3] = '{2'b10, 2'b00, 2'b01};
  logic [6:0]  addrs [3] = '{7'b0101111, 7'b0101110, 7'b0101100};

  // open drain with pull-up: low while either party pulls it
  assign sda = ~host_oe & (sda_oe ? sda_out : 1'b1);

  tmsr_top #(.CONV_CYC(T_CONV), .LOCK_CYC(T_LOCK), .TIMEOUT_CYC(T_TOUT)) u_tmsr_top (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_tied_high(addr_hi), .addr_tied_low(addr_lo), .meas(meas),
    .conv_start(conv_start), .conv_active(conv_active)
  );
  tmsr_host u_tmsr_host (.scl(scl), .sda_oe(host_oe), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the converter answers every start pulse in the same clock cycle, 1 ns after the edge
  always begin
    @(posedge clk);
    #1;
    cyc = cyc + 1;
    meas = '{ch1: ch1_val, ch2: ch2_val, valid: conv_start};
    if (conv_start === 1'b1) begin
      last_gap = cyc - last_t;
      last_t = cyc;
      n_starts = n_starts + 1;
    end
  end

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic head(input logic rd_n, output logic ack);
    u_tmsr_host.start();
    u_tmsr_host.send_byte({dev_addr, rd_n}, ack);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    logic a0, a1, a2;
    head(1'b0, a0);
    u_tmsr_host.send_byte(cmd, a1);
    u_tmsr_host.send_byte(data, a2);
    u_tmsr_host.stop();
    chk_val("write acks", 3'b111, {a0, a1, a2});
  endtask

  task automatic snd(input logic [7:0] cmd);
    logic a0, a1;
    head(1'b0, a0);
    u_tmsr_host.send_byte(cmd, a1);
    u_tmsr_host.stop();
    chk_val("send acks", 2'b11, {a0, a1});
  endtask

  task automatic rcv(input logic [7:0] exp, input string what);
    logic       a0;
    logic [7:0] b;
    head(1'b1, a0);
    u_tmsr_host.recv_byte(1'b0, b);
    u_tmsr_host.stop();
    chk_val("receive ack", 1, a0);
    chk_byte(what, exp, b);
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
    logic       a0, a1, a2;
    logic [7:0] b;
    head(1'b0, a0);
    u_tmsr_host.send_byte(cmd, a1);
    head(1'b1, a2);
    u_tmsr_host.recv_byte(1'b0, b);
    u_tmsr_host.stop();
    chk_val("read acks", 3'b111, {a0, a1, a2});
    chk_byte(what, exp, b);
  endtask

  task automatic wait_conv();
    int n0;
    n0 = n_starts;
    for (int i = 0; i < 3 * T_CONV && n_starts < n0 + 2; i++) @(posedge clk);
    chk_val("conversions seen", 1, n_starts >= n0 + 2);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    int   n0;
    logic a;
    sys_rst = 1'b1;
    ce = 1'b1;
    {addr_hi, addr_lo} = 2'b01;
    {ch1_val, ch2_val} = 24'h000000;
    dev_addr = 7'b0101100;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 10 && n_starts == 0; i++) @(posedge clk);
    chk_val("start after reset", 1, n_starts > 0);
    wait_conv();
    chk_val("conversion spacing", T_CONV, last_gap);
    rd(REG_GLOBAL_CFG, 8'h00, "config reset value");
    rd(8'h02, 8'h00, "unmapped offset");
    $display("test reset_and_rate done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #1 {addr_hi, addr_lo} = straps[k];
      repeat (8) @(posedge clk);
      dev_addr = addrs[k];
      wr(REG_GLOBAL_CFG, 8'h00);
      dev_addr = addrs[(k + 1) % 3];
      head(1'b0, a);
      u_tmsr_host.stop();
      chk_val("foreign address ack", 0, a);
    end
    dev_addr = addrs[2];
    $display("test address_select done");
    for (int i = 0; i < 4; i++) begin
      ch1_val = tv[i];
      ch2_val = tv[3 - i];
      wait_conv();
      rd(REG_CH1_FRAC, tf[i], "ch1 fraction");
      rd(REG_CH2_FRAC, tf[3 - i], "ch2 fraction");
      rd(REG_CH1_TEMP, tm[i], "ch1 main");
      rd(REG_CH2_TEMP, tm[3 - i], "ch2 main");
    end
    $display("test temperature_format done");
    ch1_val = tv[0];
    wait_conv();
    rd(REG_CH1_FRAC, tf[0], "ch1 fraction");
    ch1_val = 12'd400;
    wait_conv();
    rd(REG_CH1_TEMP, tm[0], "ch1 main held");
    wait_conv();
    rd(REG_CH1_TEMP, 8'h32, "ch1 main released");
    rd(REG_CH1_FRAC, 8'h00, "ch1 fraction");
    ch1_val = 12'd8;
    repeat (T_LOCK + 2 * T_CONV) @(posedge clk);
    rd(REG_CH1_TEMP, 8'h01, "ch1 main after hold");
    $display("test fraction_lock done");
    wr(REG_CH1_TEMP, 8'h55);
    rcv(8'h01, "ch1 main after write");
    snd(REG_CH2_FRAC);
    rcv(tf[0], "ch2 fraction by pointer");
    $display("test short_forms done");
    wr(REG_GLOBAL_CFG, 8'hA5);
    chk_val("conv_active stopped", 0, conv_active);
    n0 = n_starts;
    ch1_val = 12'd800;
    repeat (2 * T_CONV) @(posedge clk);
    chk_val("starts while stopped", n0, n_starts);
    rd(REG_CH1_TEMP, 8'h01, "ch1 main while stopped");
    rd(REG_GLOBAL_CFG, 8'hA5, "config readback");
    wr(REG_GLOBAL_CFG, 8'h00);
    chk_val("conv_active running", 1, conv_active);
    wait_conv();
    rd(REG_CH1_TEMP, 8'h64, "ch1 main resumed");
    $display("test shutdown done");
    snd(REG_GLOBAL_CFG);
    head(1'b1, a);
    repeat (20) @(posedge clk);
    #1;
    chk_val("data bit pulled low", 1, sda_oe);
    repeat (T_TOUT + 20) @(posedge clk);
    #1;
    chk_val("released after timeout", 0, sda_oe);
    u_tmsr_host.stop();
    rd(REG_GLOBAL_CFG, 8'h00, "config after timeout");
    $display("test bus_timeout done");
    wrap_up();
  end

  // tests need about 45000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    wrap_up();
  end
endmodule
`default_nettype wire
